/* File: scr_pkg.sv */
package scr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register addresses, one byte each
    localparam logic [15:0] ADDR_CTRL_ZERO = 16'h0029;
    localparam logic [15:0] ADDR_CTRL_ONE  = 16'h002A;
    localparam logic [15:0] ADDR_CTRL_TWO  = 16'h002B;
    localparam logic [15:0] ADDR_POS_LO    = 16'h002C;
    localparam logic [15:0] ADDR_POS_MID   = 16'h002D;
    localparam logic [15:0] ADDR_POS_HI    = 16'h002E;

    ////////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [7:0]  RST_CTRL_ZERO  = 8'h00;
    localparam logic [7:0]  RST_CTRL_ONE   = 8'h00;
    localparam logic [7:0]  RST_CTRL_TWO   = 8'h11;
    localparam logic [23:0] RST_POS        = 24'h000000;
    localparam logic [7:0]  RD_UNMAPPED    = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // field positions, control zero
    localparam int BIT_PROC_EN    = 6;
    localparam int BIT_RECV_EN    = 5;
    localparam int BIT_ZOOM       = 4;
    localparam int SEL_MSB        = 3;
    localparam int SEL_LSB        = 0;
    // field positions, control one
    localparam int BIT_TS_EN      = 3;
    localparam int BIT_DEVCLK_DC  = 2;
    localparam int BIT_SYSREF_DC  = 1;
    localparam int BIT_INVERT     = 0;
    // field positions, control two
    localparam int BIT_GAIN       = 4;
    localparam int BIT_NOISE      = 2;
    localparam int DEL_MSB        = 1;
    localparam int DEL_LSB        = 0;
    // sample width; the timestamp slot is bit 0, fixed in scr_regs
    localparam int SAMPLE_W       = 12;

    ////////////////////////////////////////////////////////////////////////////
    // decoded control fields driven to the converter
    typedef struct packed {
        logic       processor_enable;
        logic       receiver_enable;
        logic       capture_delay_fine_steps;
        logic [3:0] capture_delay_select;
        logic       sysref_timestamp_enable;
        logic       device_clock_dc_input_mode;
        logic       sysref_dc_input_mode;
        logic       polarity_invert;
        logic       clock_converter_gain;
        logic       supply_noise_suppress_enable;
        logic [1:0] sampling_clock_delay;
    } scr_ctrl_t;

endpackage

/* File: scr_regs.sv */
`timescale 1ns/1ps
module scr_regs (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic [15:0]               reg_addr_i,
    input  wire logic                      reg_wr_i,
    input  wire logic [7:0]                reg_wdata_i,
    input  wire logic                      reg_rd_i,
    output logic      [7:0]                reg_rdata_o,
    output logic                           reg_rvalid_o,
    input  wire logic                      sysref_i,
    input  wire logic [23:0]               capture_position_i,
    input  wire logic                      sample_timestamp_enable_i,
    input  wire logic                      decimation_bypass_i,
    input  wire logic [scr_pkg::SAMPLE_W-1:0] sample_i,
    input  wire logic                      sample_valid_i,
    output logic      [scr_pkg::SAMPLE_W-1:0] sample_o,
    output logic                           sample_valid_o,
    output logic                           sysref_event_o,
    output scr_pkg::scr_ctrl_t             ctrl_o
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0]  ctrl_zero;
    logic [7:0]  ctrl_one;
    logic [7:0]  ctrl_two;
    logic [23:0] position;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        sync_first;
    logic        sync_second;
    logic        level_prev;
    logic        event_q;
    logic [scr_pkg::SAMPLE_W-1:0] sample_q;
    logic        sample_valid_q;

    logic [7:0]  next_ctrl_zero;
    logic [7:0]  next_ctrl_one;
    logic [7:0]  next_ctrl_two;
    logic [23:0] next_position;
    logic [7:0]  next_rdata;
    logic        next_rvalid;
    logic        next_level_prev;
    logic        next_event_q;
    logic [scr_pkg::SAMPLE_W-1:0] next_sample_q;
    logic        next_sample_valid_q;

    logic        sysref_level;
    logic        sysref_rise;
    logic        insert_stamp;

    // byte lane of a readable address, unmapped reads as zero
    function automatic logic [7:0] read_mux(input logic [15:0] addr,
                                            input logic [7:0]  c0,
                                            input logic [7:0]  c1,
                                            input logic [7:0]  c2,
                                            input logic [23:0] pos);
        logic [7:0] r;
        r = scr_pkg::RD_UNMAPPED;
        case (addr)
            scr_pkg::ADDR_CTRL_ZERO: r = c0;
            scr_pkg::ADDR_CTRL_ONE:  r = c1;
            scr_pkg::ADDR_CTRL_TWO:  r = c2;
            scr_pkg::ADDR_POS_LO:    r = pos[7:0];
            scr_pkg::ADDR_POS_MID:   r = pos[15:8];
            scr_pkg::ADDR_POS_HI:    r = pos[23:16];
            default:                 r = scr_pkg::RD_UNMAPPED;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin path: two flops before any logic looks at the pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_first  <= 1'b0;
            sync_second <= 1'b0;
        end else begin
            sync_first  <= sysref_i;
            sync_second <= sync_first;
        end
    end

    // receiver gates the level, inversion applied before alignment use
    assign sysref_level = ctrl_zero[scr_pkg::BIT_RECV_EN]
                        & (sync_second ^ ctrl_one[scr_pkg::BIT_INVERT]);
    assign sysref_rise  = sysref_level & ~level_prev;
    // stamping needs both enables and a bypassed down-converter
    assign insert_stamp = ctrl_one[scr_pkg::BIT_TS_EN]
                        & sample_timestamp_enable_i
                        & decimation_bypass_i;

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic for the register bank and the read answer
    always_comb begin
        next_ctrl_zero = ctrl_zero;
        next_ctrl_one  = ctrl_one;
        next_ctrl_two  = ctrl_two;
        next_rdata     = rdata;
        next_rvalid    = reg_rd_i;
        // all eight bits stored, reserved ones included; status is not writable
        if (reg_wr_i) begin
            case (reg_addr_i)
                scr_pkg::ADDR_CTRL_ZERO: next_ctrl_zero = reg_wdata_i;
                scr_pkg::ADDR_CTRL_ONE:  next_ctrl_one  = reg_wdata_i;
                scr_pkg::ADDR_CTRL_TWO:  next_ctrl_two  = reg_wdata_i;
                default:                 next_ctrl_zero = ctrl_zero;
            endcase
        end
        // read data sampled in the request cycle, shown one cycle later;
        // current contents are muxed, so a read beside a write sees the old byte
        if (reg_rd_i) begin
            next_rdata = read_mux(reg_addr_i, ctrl_zero, ctrl_one, ctrl_two, position);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic for pulse capture and the sample path
    always_comb begin
        next_position       = position;
        next_level_prev     = sysref_level;
        next_event_q        = 1'b0;
        next_sample_q       = sample_i;
        next_sample_valid_q = sample_valid_i;
        // events only count with the processor running; the receiver
        // gate is kept too, so a wrong enable order cannot fire on noise
        if (sysref_rise && ctrl_zero[scr_pkg::BIT_PROC_EN]) begin
            next_event_q  = 1'b1;
            next_position = capture_position_i;
        end
        // pulse level replaces the sample LSB
        if (insert_stamp) begin
            next_sample_q[0] = sysref_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register bank and read answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_zero      <= scr_pkg::RST_CTRL_ZERO;
            ctrl_one       <= scr_pkg::RST_CTRL_ONE;
            ctrl_two       <= scr_pkg::RST_CTRL_TWO;
            rdata          <= 8'h00;
            rvalid         <= 1'b0;
        end else begin
            ctrl_zero      <= next_ctrl_zero;
            ctrl_one       <= next_ctrl_one;
            ctrl_two       <= next_ctrl_two;
            rdata          <= next_rdata;
            rvalid         <= next_rvalid;
        end
    end

    // capture and sample registers; position cleared although it is
    // undefined until the first capture, so reads stay deterministic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            position       <= scr_pkg::RST_POS;
            level_prev     <= 1'b0;
            event_q        <= 1'b0;
            sample_q       <= '0;
            sample_valid_q <= 1'b0;
        end else begin
            position       <= next_position;
            level_prev     <= next_level_prev;
            event_q        <= next_event_q;
            sample_q       <= next_sample_q;
            sample_valid_q <= next_sample_valid_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from flops
    assign reg_rdata_o    = rdata;
    assign reg_rvalid_o   = rvalid;
    assign sysref_event_o = event_q;
    assign sample_o       = sample_q;
    assign sample_valid_o = sample_valid_q;

    // control fields to the analog and timing side
    assign ctrl_o.processor_enable             = ctrl_zero[scr_pkg::BIT_PROC_EN];
    assign ctrl_o.receiver_enable              = ctrl_zero[scr_pkg::BIT_RECV_EN];
    assign ctrl_o.capture_delay_fine_steps     = ctrl_zero[scr_pkg::BIT_ZOOM];
    assign ctrl_o.capture_delay_select         =
        ctrl_zero[scr_pkg::SEL_MSB:scr_pkg::SEL_LSB];
    assign ctrl_o.sysref_timestamp_enable      = ctrl_one[scr_pkg::BIT_TS_EN];
    assign ctrl_o.device_clock_dc_input_mode   = ctrl_one[scr_pkg::BIT_DEVCLK_DC];
    assign ctrl_o.sysref_dc_input_mode         = ctrl_one[scr_pkg::BIT_SYSREF_DC];
    assign ctrl_o.polarity_invert              = ctrl_one[scr_pkg::BIT_INVERT];
    assign ctrl_o.clock_converter_gain         = ctrl_two[scr_pkg::BIT_GAIN];
    assign ctrl_o.supply_noise_suppress_enable = ctrl_two[scr_pkg::BIT_NOISE];
    // not forced one-hot: a bad code from the host passes through as written
    assign ctrl_o.sampling_clock_delay         =
        ctrl_two[scr_pkg::DEL_MSB:scr_pkg::DEL_LSB];

endmodule // scr_regs

/* File: scr_regs_asserts.sv */
`timescale 1ns/1ps
module scr_regs_asserts (
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic [15:0]        reg_addr_i,
    input wire logic               reg_wr_i,
    input wire logic [7:0]         reg_wdata_i,
    input wire logic               reg_rd_i,
    input wire logic [7:0]         reg_rdata_o,
    input wire logic               reg_rvalid_o,
    input wire logic               sample_timestamp_enable_i,
    input wire logic               decimation_bypass_i,
    input wire logic [11:0]        sample_i,
    input wire logic [11:0]        sample_o,
    input wire logic               sysref_event_o,
    input wire scr_pkg::scr_ctrl_t ctrl_o
);
    ////////////////////////////////////////////////////////////////////////////
    // one clock domain, so clock and disable are declared once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // stamping condition, held off unless all three enables agree
    wire stamp = ctrl_o.sysref_timestamp_enable & sample_timestamp_enable_i & decimation_bypass_i;
    chk_event_gated: assert property (sysref_event_o |-> $past(ctrl_o.processor_enable))
        else $error("event while processor disabled");
    chk_event_pulse: assert property (sysref_event_o |=> !sysref_event_o)
        else $error("event longer than one cycle");
    chk_plain_sample: assert property (!stamp |=> sample_o == $past(sample_i))
        else $error("sample altered without stamping");
    chk_stamp_upper: assert property (stamp |=> sample_o[11:1] == $past(sample_i[11:1]))
        else $error("stamping touched upper bits");
    chk_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read answer missing");
    chk_read_quiet: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("read answer without a read");
    chk_rdata_hold: assert property (!reg_rvalid_o |-> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    chk_ctrl_two_rst: assert property ($fell(rst_i) |-> ctrl_o.sampling_clock_delay == 2'h1
        && ctrl_o.clock_converter_gain)
        else $error("control two reset value wrong");
    chk_ctrl_one_rst: assert property ($fell(rst_i) |-> !ctrl_o.polarity_invert
        && !ctrl_o.sysref_timestamp_enable)
        else $error("control one reset value wrong");
    chk_invert_write: assert property (reg_wr_i && reg_addr_i == scr_pkg::ADDR_CTRL_ONE
        |=> ctrl_o.polarity_invert == $past(reg_wdata_i[0]))
        else $error("invert bit not taken");
    chk_select_write: assert property (reg_wr_i && reg_addr_i == scr_pkg::ADDR_CTRL_ZERO
        |=> ctrl_o.capture_delay_select == $past(reg_wdata_i[3:0]))
        else $error("delay select not taken");
endmodule // scr_regs_asserts
bind scr_regs scr_regs_asserts u_chk (.clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
    .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .sample_timestamp_enable_i, .decimation_bypass_i,
    .sample_i, .sample_o, .sysref_event_o, .ctrl_o);

/* File: scr_sysref_src.sv */
`timescale 1ns/1ps
module scr_sysref_src (
    input  wire logic clk_i,
    input  wire logic fire_i,
    output logic      sysref_o
);
    int unsigned hi_left = 0;
    initial sysref_o = 1'b0;
    // pulse of three cycles, low between so each one is a clean edge
    always @(posedge clk_i) begin
        if (fire_i) hi_left = 3;
        sysref_o <= (hi_left != 0);
        if (hi_left != 0) hi_left--;
    end
endmodule // scr_sysref_src

/* File: scr_regs_tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED %0t got %h want %h", $time, (a), (e)); end end
module scr_regs_tb;
    logic               clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic [15:0]        reg_addr_i = 16'h0000;
    logic               reg_wr_i = 1'b0;
    logic [7:0]         reg_wdata_i = 8'h00;
    logic               reg_rd_i = 1'b0;
    logic [7:0]         reg_rdata_o;
    logic               reg_rvalid_o;
    logic               sysref_i;
    logic               fire = 1'b0;
    logic [23:0]        pos = 24'h000000;
    logic               ts_en = 1'b0;
    logic               bypass = 1'b0;
    logic [11:0]        smp = 12'h000;
    logic [11:0]        sample_o;
    logic               sample_valid_o;
    logic               sysref_event_o;
    scr_pkg::scr_ctrl_t ctrl_o;
    int                 err_count = 0;
    int                 compares = 0;
    int                 evt_count = 0;
    ////////////////////////////////////////////////////////////////////////////
    initial forever #10 clk_i = ~clk_i;
    scr_sysref_src u_src (.clk_i(clk_i), .fire_i(fire), .sysref_o(sysref_i));
    scr_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .sysref_i(sysref_i), .capture_position_i(pos),
        .sample_timestamp_enable_i(ts_en), .decimation_bypass_i(bypass), .sample_i(smp),
        .sample_valid_i(1'b1), .sample_o(sample_o), .sample_valid_o(sample_valid_o),
        .sysref_event_o(sysref_event_o), .ctrl_o(ctrl_o));
    // count processed pulses; only a known high counts
    always @(posedge clk_i) if (sysref_event_o === 1'b1) evt_count <= evt_count + 1;
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i); reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1;
        @(posedge clk_i); reg_wr_i <= 1'b0;
    endtask
    // answer is fixed at one cycle, so no open wait is needed
    task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_i); reg_addr_i <= a; reg_rd_i <= 1'b1;
        @(posedge clk_i); reg_rd_i <= 1'b0;
        #1 `CHK(reg_rvalid_o, 1'b1)
        `CHK(reg_rdata_o, e)
    endtask
    // two sync flops plus event register: six cycles is ample
    task automatic pulse();
        @(posedge clk_i); fire <= 1'b1;
        @(posedge clk_i); fire <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic conclude();
        $display("compares %0d, errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #1000000 err_count++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(scr_pkg::ADDR_CTRL_ZERO, 8'h00);
        rdchk(scr_pkg::ADDR_CTRL_ONE, 8'h00);
        rdchk(scr_pkg::ADDR_CTRL_TWO, 8'h11);
        rdchk(scr_pkg::ADDR_POS_HI, 8'h00);
        rdchk(16'h0040, scr_pkg::RD_UNMAPPED);
        wr(scr_pkg::ADDR_CTRL_TWO, 8'hEA); rdchk(scr_pkg::ADDR_CTRL_TWO, 8'hEA);
        wr(scr_pkg::ADDR_CTRL_ONE, 8'hF0); rdchk(scr_pkg::ADDR_CTRL_ONE, 8'hF0);
        wr(scr_pkg::ADDR_POS_LO, 8'h77); rdchk(scr_pkg::ADDR_POS_LO, 8'h00);
        // receiver alone first, processor later
        wr(scr_pkg::ADDR_CTRL_ZERO, 8'hB5); rdchk(scr_pkg::ADDR_CTRL_ZERO, 8'hB5);
        pos <= 24'hABCDEF;
        pulse(); `CHK(evt_count, 0)
        wr(scr_pkg::ADDR_CTRL_ZERO, 8'h70); pulse(); `CHK(evt_count, 1)
        `CHK(ctrl_o.capture_delay_fine_steps, 1'b1)
        rdchk(scr_pkg::ADDR_POS_LO, 8'hEF);
        rdchk(scr_pkg::ADDR_POS_MID, 8'hCD);
        rdchk(scr_pkg::ADDR_POS_HI, 8'hAB);
        // inverting an idle-low pulse gives a rising level
        wr(scr_pkg::ADDR_CTRL_ONE, 8'h09); repeat (6) @(posedge clk_i);
        `CHK(evt_count, 2)
        ts_en <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_i); bypass <= i[0]; smp <= 12'hABC;
            @(posedge clk_i);
            #1 `CHK(sample_o, (i == 1) ? 12'hABD : 12'hABC)
            `CHK(sample_valid_o, 1'b1)
        end
        conclude();
    end
endmodule // scr_regs_tb
